//--- design/drv_cfg_pkg.sv
// Shared constants for the output configuration and routing block
package drv_cfg_pkg;
  localparam int NUM_IN  = 8;
  localparam int NUM_DRV = 4;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_CONFIG  = 8'h00;
  localparam logic [7:0] OFF_GENERAL = 8'h04;
  localparam logic [7:0] OFF_COMMAND = 8'h08;
  localparam logic [7:0] OFF_STATUS  = 8'h0c;

  // Field positions
  localparam int GEN_PWM_EN_BIT = 0;
  localparam int GEN_HS_SEL_BIT = 8;
  localparam int CMD_DRV_LSB    = 8;
  localparam int ST_EN_BIT      = 2;
  localparam int ST_LSO_LSB     = 8;
  localparam int ST_DRN_LSB     = 16;
  localparam int ST_SRC_LSB     = 20;

  // Configuration codes
  localparam logic [1:0] CFG_LS8    = 2'h0;
  localparam logic [1:0] CFG_LS_PWM = 2'h1;
  localparam logic [1:0] CFG_HS_PWM = 2'h2;
  localparam logic [1:0] CFG_FLEX   = 2'h3;

  // Reset values
  localparam logic [1:0]  CFG_RST = 2'h0;
  localparam logic [31:0] GEN_RST = 32'h0000_0000;
  localparam logic [31:0] CMD_RST = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Dead time between partner switches
  localparam int CLK_PERIOD_NS = 100;
  localparam int GAP_TIME_NS   = 2000;
  localparam int GAP_CYC =
    (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : drv_cfg_pkg

//--- design/freewheel_seq.sv
// Break-before-make sequencer for one PWM switch and its free-wheel partner
`timescale 1ns/100ps
module freewheel_seq #(
  parameter int GAP_CYC = drv_cfg_pkg::GAP_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic active,
  input  wire logic req,
  input  wire logic pri_low,
  input  wire logic fw_low,
  output logic      pri_on,
  output logic      fw_on
);
  import drv_cfg_pkg::*;

  localparam int GAP_W = $clog2(GAP_CYC + 1);

  typedef enum logic [1:0] {
    S_FW_ON, S_TO_PRI, S_PRI_ON, S_TO_FW
  } seq_st_t;

  seq_st_t          st_q;
  seq_st_t          st_d;
  logic [GAP_W-1:0] cnt_q;
  logic [GAP_W-1:0] cnt_d;
  logic [GAP_W-1:0] pri_run_q;
  logic [GAP_W-1:0] fw_run_q;
  wire              gap_end = (cnt_q == GAP_W'(GAP_CYC - 1));

  always_comb begin
    st_d  = st_q;
    cnt_d = '0;
    case (st_q)
      S_FW_ON: begin
        if (req) st_d = S_TO_PRI;
      end
      S_TO_PRI: begin
        if (!req) st_d = S_TO_FW;
        else if (fw_low) begin
          if (gap_end) st_d = S_PRI_ON;
          else cnt_d = cnt_q + GAP_W'(1);
        end
      end
      S_PRI_ON: begin
        if (!req) st_d = S_TO_FW;
      end
      S_TO_FW: begin
        if (req) st_d = S_TO_PRI;
        else if (pri_low) begin
          if (gap_end) st_d = S_FW_ON;
          else cnt_d = cnt_q + GAP_W'(1);
        end
      end
      default: st_d = S_TO_FW;
    endcase
    if (!active) begin
      st_d  = S_TO_FW;
      cnt_d = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q  <= S_TO_FW;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign pri_on = (st_q == S_PRI_ON);
  assign fw_on  = (st_q == S_FW_ON);

  // Consecutive gate-low cycles, used only by the checks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_run_q <= '0;
      fw_run_q  <= '0;
    end else begin
      pri_run_q <= !pri_low ? '0 : pri_run_q + GAP_W'(&pri_run_q ? 0 : 1);
      fw_run_q  <= !fw_low ? '0 : fw_run_q + GAP_W'(&fw_run_q ? 0 : 1);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_no_overlap: assert property (!(pri_on && fw_on))
    else $error("both switches of a pair are on");
  chk_gap_pri_on: assert property (
    $rose(pri_on) |-> fw_run_q >= GAP_W'(GAP_CYC))
    else $error("primary switch turned on before the dead time");
  chk_gap_fw_on: assert property (
    $rose(fw_on) |-> pri_run_q >= GAP_W'(GAP_CYC))
    else $error("free-wheel switch turned on before the dead time");
endmodule : freewheel_seq

//--- design/driver_config_routing.sv
// Output configuration, routing and PWM sequencing with AXI4-Lite registers
// Functional notes
// - Two-bit code selects configurations one to four
// - New code applies only while enable low
// - Config four: drivers serial only, bit8 side
// - Config four: inputs one-eight drive outputs one-eight
// - Config one: paired outputs and drains per input one-four
// - Config two needs PWM enable bit set
// - Config two: source on one gap after paired output off
// - Config two ON: source off, gap, output on
// - Config two OFF: output off, gap, source on
// - Config three needs PWM enable bit set
// - Config three: output conducts while paired source off
// - Config three OFF: source off, gap, output on
// - Configs two, three: inputs five-eight direct
// - Request is serial bit OR parallel input
// - All outputs off while enable low
// - Reset clears registers and switches outputs off
`timescale 1ns/100ps
module driver_config_routing #(
  parameter int GAP_CYC = drv_cfg_pkg::GAP_CYC
) (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [drv_cfg_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                            awvalid,
  output logic                                 awready,
  input  wire logic [drv_cfg_pkg::DATA_W-1:0]  wdata,
  input  wire logic [3:0]                      wstrb,
  input  wire logic                            wvalid,
  output logic                                 wready,
  output logic [1:0]                           bresp,
  output logic                                 bvalid,
  input  wire logic                            bready,
  input  wire logic [drv_cfg_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                            arvalid,
  output logic                                 arready,
  output logic [drv_cfg_pkg::DATA_W-1:0]       rdata,
  output logic [1:0]                           rresp,
  output logic                                 rvalid,
  input  wire logic                            rready,
  input  wire logic                            output_enable,
  input  wire logic [drv_cfg_pkg::NUM_IN-1:0]  parallel_drive_inputs,
  input  wire logic [drv_cfg_pkg::NUM_DRV-1:0] hs_gate_low,
  input  wire logic [drv_cfg_pkg::NUM_DRV-1:0] ls_gate_low,
  output logic [drv_cfg_pkg::NUM_IN-1:0]       low_side_outputs,
  output logic [drv_cfg_pkg::NUM_DRV-1:0]      config_driver_drain,
  output logic [drv_cfg_pkg::NUM_DRV-1:0]      config_driver_source
);
  import drv_cfg_pkg::*;

  // Bus slave state
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [ADDR_W-1:0] raddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;

  // Control registers
  logic [1:0]        cfg_req_q;
  logic [1:0]        cfg_q;
  logic [31:0]       gen_q;
  logic [31:0]       cmd_q;

  // Output stage
  logic [NUM_IN-1:0]  lso_q;
  logic [NUM_DRV-1:0] drn_q;
  logic [NUM_DRV-1:0] src_q;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : merge

  // Write path: address and data taken in either order
  wire aw_take = awvalid && awready_q;
  wire w_take  = wvalid && wready_q;
  wire wr_go   = !awready_q && !wready_q && !bvalid_q;
  wire b_done  = bvalid_q && bready;
  wire wr_cfg  = wr_go && (waddr_q[ADDR_W-1:2] == OFF_CONFIG[ADDR_W-1:2]);
  wire wr_gen  = wr_go && (waddr_q[ADDR_W-1:2] == OFF_GENERAL[ADDR_W-1:2]);
  wire wr_cmd  = wr_go && (waddr_q[ADDR_W-1:2] == OFF_COMMAND[ADDR_W-1:2]);
  wire wr_sts  = waddr_q[ADDR_W-1:2] == OFF_STATUS[ADDR_W-1:2];
  wire wr_ok   = wr_cfg || wr_gen || wr_cmd || wr_sts;

  // Read path
  wire ar_take = arvalid && arready_q;
  wire rd_go   = !arready_q && !rvalid_q;
  wire r_done  = rvalid_q && rready;
  wire [ADDR_W-3:0] ridx = raddr_q[ADDR_W-1:2];
  wire rd_cfg  = ridx == OFF_CONFIG[ADDR_W-1:2];
  wire rd_gen  = ridx == OFF_GENERAL[ADDR_W-1:2];
  wire rd_cmd  = ridx == OFF_COMMAND[ADDR_W-1:2];
  wire rd_sts  = ridx == OFF_STATUS[ADDR_W-1:2];
  wire [31:0] status_w = {8'h00, src_q, drn_q, lso_q, 5'h00,
                          output_enable, cfg_q};
  wire [31:0] rd_mux = rd_cfg ? {30'h0, cfg_req_q} :
                       rd_gen ? gen_q :
                       rd_cmd ? cmd_q :
                       rd_sts ? status_w : 32'h0;
  wire rd_ok = rd_cfg || rd_gen || rd_cmd || rd_sts;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      waddr_q   <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (aw_take) begin
        awready_q <= 1'b0;
        waddr_q   <= awaddr;
      end
      if (w_take) begin
        wready_q <= 1'b0;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_done) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
      raddr_q   <= '0;
    end else begin
      if (ar_take) begin
        arready_q <= 1'b0;
        raddr_q   <= araddr;
      end
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (r_done) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Control registers; the active code follows only with outputs disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_req_q <= CFG_RST;
      cfg_q     <= CFG_RST;
      gen_q     <= GEN_RST;
      cmd_q     <= CMD_RST;
    end else begin
      if (wr_cfg && wstrb_q[0]) cfg_req_q <= wdata_q[1:0];
      if (!output_enable) cfg_q <= cfg_req_q;
      if (wr_gen) gen_q <= merge(gen_q, wdata_q, wstrb_q);
      if (wr_cmd) cmd_q <= merge(cmd_q, wdata_q, wstrb_q);
    end
  end

  // Routing
  wire cfg1   = (cfg_q == CFG_LS8);
  wire cfg2   = (cfg_q == CFG_LS_PWM);
  wire cfg3   = (cfg_q == CFG_HS_PWM);
  wire cfg4   = (cfg_q == CFG_FLEX);
  wire hs_sel = gen_q[GEN_HS_SEL_BIT];
  wire pwm_en = gen_q[GEN_PWM_EN_BIT];
  wire pwm_act = output_enable && pwm_en && (cfg2 || cfg3);
  wire [NUM_IN-1:0]  ch = cmd_q[NUM_IN-1:0] | parallel_drive_inputs;
  wire [NUM_DRV-1:0] drv_cmd = cmd_q[CMD_DRV_LSB +: NUM_DRV];

  logic [NUM_DRV-1:0] pri_on;
  logic [NUM_DRV-1:0] fw_on;
  logic [NUM_DRV-1:0] seq_lso;
  logic [NUM_DRV-1:0] seq_src;

  // Pair partner of channel i is channel i^1
  for (genvar i = 0; i < NUM_DRV; i++) begin : g_pair
    localparam int P = i ^ 1;
    wire pri_low = cfg3 ? hs_gate_low[i] : ls_gate_low[i];
    wire fw_low  = cfg3 ? ls_gate_low[P] : hs_gate_low[P];

    freewheel_seq #(
      .GAP_CYC (GAP_CYC)
    ) u_seq (
      .aclk    (aclk),
      .aresetn (aresetn),
      .active  (pwm_act),
      .req     (ch[i]),
      .pri_low (pri_low),
      .fw_low  (fw_low),
      .pri_on  (pri_on[i]),
      .fw_on   (fw_on[i])
    );

    assign seq_lso[i] = cfg3 ? fw_on[P] : pri_on[i];
    assign seq_src[i] = cfg3 ? pri_on[i] : fw_on[P];
  end

  wire [NUM_IN-1:0] lso_sel =
    cfg1 ? {ch[7:4], {2{ch[1]}}, {2{ch[0]}}} :
    cfg4 ? ch :
           {ch[7:4], seq_lso};
  wire [NUM_DRV-1:0] drn_sel =
    cfg1 ? {{2{ch[3]}}, {2{ch[2]}}} :
    (cfg4 && !hs_sel) ? drv_cmd : '0;
  wire [NUM_DRV-1:0] src_sel =
    (cfg4 && hs_sel) ? drv_cmd :
    (cfg2 || cfg3)   ? seq_src : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn || !output_enable) begin
      lso_q <= '0;
      drn_q <= '0;
      src_q <= '0;
    end else begin
      lso_q <= lso_sel;
      drn_q <= drn_sel;
      src_q <= src_sel;
    end
  end

  assign awready              = awready_q;
  assign wready               = wready_q;
  assign bvalid               = bvalid_q;
  assign bresp                = bresp_q;
  assign arready              = arready_q;
  assign rvalid               = rvalid_q;
  assign rresp                = rresp_q;
  assign rdata                = rdata_q;
  assign low_side_outputs     = lso_q;
  assign config_driver_drain  = drn_q;
  assign config_driver_source = src_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_cfg_frozen_en: assert property (
    output_enable && $past(output_enable) |-> $stable(cfg_q))
    else $error("configuration changed while outputs enabled");
  chk_en_forces_off: assert property (
    !output_enable |=> lso_q == '0 && drn_q == '0 && src_q == '0)
    else $error("output active while enable low");
  chk_reset_off: assert property (
    $rose(aresetn) |-> lso_q == '0 && src_q == '0 && cfg_q == CFG_RST)
    else $error("output or code not cleared by reset");
  chk_cfg4_direct: assert property (
    cfg4 && output_enable |=> lso_q == $past(ch))
    else $error("configuration four output mismatch");
  chk_cfg4_driver: assert property (
    cfg4 && output_enable && hs_sel |=>
      src_q == $past(drv_cmd) && drn_q == '0)
    else $error("configuration four driver mismatch");
  chk_cfg1_pairs: assert property (
    cfg1 && output_enable |=> lso_q[1:0] == {2{$past(ch[0])}}
      && drn_q[3:2] == {2{$past(ch[3])}} && src_q == '0)
    else $error("configuration one pairing mismatch");
  chk_pwm_gated: assert property (
    (cfg2 || cfg3) && !pwm_en ##1 !pwm_en |=>
      lso_q[3:0] == '0 && src_q == '0)
    else $error("PWM pair driven without enable bit");
  chk_upper_direct: assert property (
    (cfg2 || cfg3) && output_enable |=> lso_q[7:4] == $past(ch[7:4]))
    else $error("upper outputs not following inputs");

  cov_cfg2_on: cover property (cfg2 && $rose(lso_q[0]));
  cov_cfg3_on: cover property (cfg3 && $rose(src_q[0]));
  cov_cfg4_hs: cover property (cfg4 && hs_sel && $rose(src_q[1]));
  cov_cfg1_drn: cover property (cfg1 && $rose(drn_q[0]));

  chk_cfg_loads_low: assert property (
    !output_enable |=> cfg_q == $past(cfg_req_q))
    else $error("active code not loaded while outputs disabled");
  chk_cfg1_drains: assert property (
    cfg1 && output_enable |=> drn_q[1:0] == {2{$past(ch[2])}}
      && lso_q[3:2] == {2{$past(ch[1])}})
    else $error("configuration one drain pairing mismatch");
  chk_cfg4_low_side: assert property (
    cfg4 && output_enable && !hs_sel |=>
      drn_q == $past(drv_cmd) && src_q == '0)
    else $error("configuration four low-side driver mismatch");
  chk_bvalid_holds: assert property (
    bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped before it was taken");
  chk_rvalid_holds: assert property (
    rvalid_q && !rready |=> rvalid_q && $stable(rdata_q))
    else $error("read data dropped before it was taken");

  // Off time of each pin pair, seen at the pins themselves
  localparam int RUN_W = $clog2(GAP_CYC + 2);
  localparam logic [RUN_W-1:0] RUN_MAX = RUN_W'(GAP_CYC + 1);
  localparam logic [RUN_W-1:0] RUN_GAP = RUN_W'(GAP_CYC);

  // Block j owns output j and its partner source j^1
  for (genvar j = 0; j < NUM_DRV; j++) begin : g_dead
    localparam int Q = j ^ 1;
    logic [RUN_W-1:0] lso_off_q;
    logic [RUN_W-1:0] src_off_q;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        lso_off_q <= '0;
        src_off_q <= '0;
      end else begin
        lso_off_q <= lso_q[j] ? '0 :
                     lso_off_q + RUN_W'(lso_off_q != RUN_MAX);
        src_off_q <= src_q[Q] ? '0 :
                     src_off_q + RUN_W'(src_off_q != RUN_MAX);
      end
    end

    chk_pair_exclusive: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (cfg2 || cfg3) |-> !(lso_q[j] && src_q[Q]))
      else $error("switch and free-wheel partner both on");
    chk_lso_dead_time: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (cfg2 || cfg3) && $rose(lso_q[j]) |-> src_off_q >= RUN_GAP)
      else $error("output turned on before the dead time");
    chk_src_dead_time: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (cfg2 || cfg3) && $rose(src_q[Q]) |-> lso_off_q >= RUN_GAP)
      else $error("source turned on before the dead time");
  end
endmodule : driver_config_routing

//--- sim/gate_model.sv
// Gate voltage feedback for the four paired PWM switches
`timescale 1ns/100ps
module gate_model (
  input  wire logic       aclk,
  input  wire logic [3:0] hs_on,
  input  wire logic [3:0] ls_on,
  input  wire logic [2:0] dly,
  output logic      [3:0] hs_gate_low,
  output logic      [3:0] ls_gate_low
);
  logic [2:0] hs_cnt_q [4] = '{default: 3'h0};
  logic [2:0] ls_cnt_q [4] = '{default: 3'h0};

  // Gate reads low only dly cycles after its switch is released
  for (genvar i = 0; i < 4; i++) begin : g_sw
    always @(posedge aclk) begin
      hs_cnt_q[i] <= hs_on[i] ? 3'h0 : hs_cnt_q[i] + {2'h0, hs_cnt_q[i] != 3'h7};
      ls_cnt_q[i] <= ls_on[i] ? 3'h0 : ls_cnt_q[i] + {2'h0, ls_cnt_q[i] != 3'h7};
    end
    assign hs_gate_low[i] = !hs_on[i] && (hs_cnt_q[i] >= dly);
    assign ls_gate_low[i] = !ls_on[i] && (ls_cnt_q[i] >= dly);
  end
endmodule : gate_model

//--- sim/driver_config_routing_tb_top.sv
// Self-checking bench for the configuration and routing block
`timescale 1ns/100ps
module driver_config_routing_tb_top;
  import drv_cfg_pkg::*;
  localparam int GAP = 6;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, output_enable;
  logic        snap_q;
  logic [7:0]  awaddr, araddr, parallel_drive_inputs, low_side_outputs;
  logic [31:0] wdata, rdata, r, c;
  logic [3:0]  wstrb, hs_gate_low, ls_gate_low, up;
  logic [3:0]  config_driver_drain, config_driver_source;
  logic [1:0]  bresp, rresp;
  logic [2:0]  gate_dly;
  logic [33:0] exp_q [$];
  int          n_errors, n_checks;

  driver_config_routing #(.GAP_CYC(GAP)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .output_enable(output_enable),
    .parallel_drive_inputs(parallel_drive_inputs),
    .hs_gate_low(hs_gate_low), .ls_gate_low(ls_gate_low),
    .low_side_outputs(low_side_outputs),
    .config_driver_drain(config_driver_drain),
    .config_driver_source(config_driver_source));

  gate_model i_gates (
    .aclk(aclk), .hs_on(config_driver_source),
    .ls_on(low_side_outputs[3:0]), .dly(gate_dly),
    .hs_gate_low(hs_gate_low), .ls_gate_low(ls_gate_low));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic tally_and_finish(input bit hung);
    if (hung) n_errors++;
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input logic [33:0] got);
    logic [33:0] e;
    e = exp_q.size() ? exp_q.pop_front() : 'x;
    n_checks++;
    if (got !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
    end
  endtask : cmp

  // Result watcher: each handshake or snapshot takes the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready) cmp({rresp, rdata});
    if (bvalid && bready) cmp({bresp, 32'h0});
    if (snap_q) cmp({18'h0, config_driver_source, config_driver_drain,
                     low_side_outputs});
  end

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    int n;
    exp_q.push_back({e, 32'h0});
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) tally_and_finish(1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    int n;
    exp_q.push_back({e, d});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) tally_and_finish(1'b1);
    rready <= 1'b0;
  endtask : rd

  task automatic snap(input logic [15:0] e);
    exp_q.push_back({18'h0, e});
    @(posedge aclk);
    snap_q <= 1'b1;
    @(posedge aclk);
    snap_q <= 1'b0;
  endtask : snap

  // Toggle request of channel one, check mid-gap and settled states
  task automatic step(input logic on, input logic [15:0] em, ee);
    @(posedge aclk);
    parallel_drive_inputs[0] <= on;
    idle(GAP + 1);
    snap(em);
    idle(12);
    snap(ee);
  endtask : step

  function automatic logic [15:0] exp1(input logic [7:0] q);
    return {4'h0, q[3], q[3], q[2], q[2], q[7:4], q[1], q[1], q[0], q[0]};
  endfunction : exp1

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {output_enable, snap_q, awaddr, araddr, wdata} = '0;
    parallel_drive_inputs = 8'h00;
    wstrb = 4'hf;
    gate_dly = 3'h0;
    n_errors = 0;
    n_checks = 0;
    void'($urandom(32'h78a9b6ec));
    idle(12);
    aresetn <= 1'b1;
    rd(OFF_CONFIG, 32'h0, RESP_OKAY);
    rd(OFF_GENERAL, 32'h0, RESP_OKAY);
    rd(OFF_COMMAND, 32'h0, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h1, RESP_SLVERR);
    wr(OFF_STATUS, 32'hffff_ffff, RESP_OKAY);
    rd(OFF_STATUS, 32'h0, RESP_OKAY);
    output_enable <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      c = $urandom;
      wr(OFF_COMMAND, {24'h0, c[7:0]}, RESP_OKAY);
      parallel_drive_inputs <= r[7:0];
      idle(2);
      snap(exp1(r[7:0] | c[7:0]));
    end
    output_enable <= 1'b0;
    idle(2);
    snap(16'h0);
    parallel_drive_inputs <= 8'h00;
    wr(OFF_COMMAND, 32'h0, RESP_OKAY);
    output_enable <= 1'b1;
    wr(OFF_CONFIG, 32'h3, RESP_OKAY);
    rd(OFF_STATUS, 32'h4, RESP_OKAY);
    output_enable <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(OFF_CONFIG, k, RESP_OKAY);
      idle(2);
      rd(OFF_STATUS, k, RESP_OKAY);
    end
    output_enable <= 1'b1;
    wr(OFF_GENERAL, 32'h100, RESP_OKAY);
    wr(OFF_COMMAND, 32'ha00, RESP_OKAY);
    parallel_drive_inputs <= r[15:8];
    idle(2);
    snap({4'ha, 4'h0, r[15:8]});
    wr(OFF_GENERAL, 32'h0, RESP_OKAY);
    idle(2);
    snap({4'h0, 4'ha, r[15:8]});
    aresetn <= 1'b0;
    parallel_drive_inputs <= 8'h00;
    snap(16'h0);
    aresetn <= 1'b1;
    rd(OFF_CONFIG, 32'h0, RESP_OKAY);
    rd(OFF_COMMAND, 32'h0, RESP_OKAY);
    output_enable <= 1'b0;
    wr(OFF_CONFIG, 32'h1, RESP_OKAY);
    output_enable <= 1'b1;
    up = r[19:16];
    parallel_drive_inputs <= {up, 4'hf};
    idle(40);
    snap({8'h0, up, 4'h0});
    wr(OFF_GENERAL, 32'h1, RESP_OKAY);
    parallel_drive_inputs <= {up, 4'h0};
    idle(40);
    snap({4'hf, 4'h0, up, 4'h0});
    step(1'b1, {4'hd, 4'h0, up, 4'h0}, {4'hd, 4'h0, up, 4'h1});
    step(1'b0, {4'hd, 4'h0, up, 4'h0}, {4'hf, 4'h0, up, 4'h0});
    output_enable <= 1'b0;
    gate_dly <= 3'h4;
    wr(OFF_CONFIG, 32'h2, RESP_OKAY);
    output_enable <= 1'b1;
    idle(40);
    snap({8'h0, up, 4'hf});
    step(1'b1, {8'h0, up, 4'hd}, {4'h1, 4'h0, up, 4'hd});
    step(1'b0, {8'h0, up, 4'hd}, {8'h0, up, 4'hf});
    idle(4);
    if (exp_q.size() != 0) n_errors++;
    tally_and_finish(1'b0);
  end
endmodule : driver_config_routing_tb_top
